/* File: core/usr_defs.svh */
`ifndef USR_DEFS_SVH
`define USR_DEFS_SVH

// ----------------------------------------------------------------------
// Widths, reset value and select codes
// ----------------------------------------------------------------------
`define USR_WIDTH      8
`define USR_MSB        7
`define USR_RESET_VAL  8'h00
`define USR_SEL_HOLD   2'h0
`define USR_SEL_RIGHT  2'h1
`define USR_SEL_LEFT   2'h2
`define USR_SEL_LOAD   2'h3

`endif

/* File: core/usr_pkg.sv */
`default_nettype none
`include "usr_defs.svh"

package usr_pkg;

    typedef enum logic [1:0] {
        USR_HOLD,
        USR_RIGHT,
        USR_LEFT,
        USR_LOAD
    } usr_mode_t;

    // Shared parallel pins, split into the driven level and its output enable.
    typedef struct packed {
        logic [`USR_MSB:0] data;
        logic [`USR_MSB:0] oe;
    } usr_par_out_t;

    typedef struct packed {
        logic serial_q0;
        logic serial_q7;
    } usr_serial_out_t;

endpackage

`default_nettype wire

/* File: core/usr_shift_reg.sv */
// How it works
// - Eight-bit state changes only on clock edges.
// - Low master clear zeroes all bits.
// - Select 11 loads from parallel pins.
// - Select 01 shifts right from right serial.
// - Select 10 shifts left from left serial.
// - Select 00 holds stored value.
// - Either enable high floats parallel pins.
// - Operation continues while outputs are floated.
// - Load select also floats parallel pins.
// - End bits drive serial outputs continuously.
`default_nettype none
`include "usr_defs.svh"

module usr_shift_reg (
    input  wire logic                   mclk_in,
    input  wire logic                   srst_in,
    input  wire logic                   shift_clock_in,
    input  wire logic                   master_clear_n_in,
    input  wire logic [1:0]             mode_sel_in,
    input  wire logic                   right_shift_serial_in,
    input  wire logic                   left_shift_serial_in,
    input  wire logic                   out_en1_n_in,
    input  wire logic                   out_en2_n_in,
    input  wire logic [`USR_MSB:0]      par_data_in,
    output var usr_pkg::usr_par_out_t   par_out,
    output var usr_pkg::usr_serial_out_t serial_out
);

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    logic                     clk_prev_r;
    logic                     clk_prev_nxt;
    logic                     clk_rise;
    logic [`USR_MSB:0]        state_r;
    logic [`USR_MSB:0]        state_nxt;
    usr_pkg::usr_mode_t       mode;
    usr_pkg::usr_par_out_t    par_r;
    usr_pkg::usr_par_out_t    par_nxt;
    usr_pkg::usr_serial_out_t ser_r;
    usr_pkg::usr_serial_out_t ser_nxt;

    // ------------------------------------------------------------------
    // Helper functions
    // ------------------------------------------------------------------
    // Right shift moves every bit one place up and fills bit 0.
    function automatic logic [`USR_MSB:0] shift_right_f(
        input logic [`USR_MSB:0] value,
        input logic              fill
    );
        shift_right_f = {value[`USR_MSB-1:0], fill};
    endfunction

    // Left shift moves every bit one place down and fills the top bit.
    function automatic logic [`USR_MSB:0] shift_left_f(
        input logic [`USR_MSB:0] value,
        input logic              fill
    );
        shift_left_f = {fill, value[`USR_MSB:1]};
    endfunction

    // The select pins map one to one onto the four modes.
    function automatic usr_pkg::usr_mode_t decode_mode_f(
        input logic [1:0] sel
    );
        decode_mode_f = usr_pkg::usr_mode_t'(sel);
    endfunction

    // A rising edge is a high level that was low one system clock earlier.
    function automatic logic is_rise_f(
        input logic now_level,
        input logic prev_level
    );
        is_rise_f = now_level & ~prev_level;
    endfunction

    // The pins are driven only with both enables low and no load pending.
    function automatic logic pins_driven_f(
        input logic               en1_n,
        input logic               en2_n,
        input usr_pkg::usr_mode_t sel_mode
    );
        pins_driven_f = !en1_n && !en2_n && (sel_mode != usr_pkg::USR_LOAD);
    endfunction

    // ------------------------------------------------------------------
    // Shift clock edge detect
    // ------------------------------------------------------------------
    // The shift clock is sampled on the system clock, so it must run well
    // below half of the system clock rate; each detected edge is a
    // one-cycle enable pulse rather than a second clock.
    always_comb begin
        clk_prev_nxt = shift_clock_in;
        clk_rise     = is_rise_f(shift_clock_in, clk_prev_r);
        mode         = decode_mode_f(mode_sel_in);
    end

    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            clk_prev_r <= 1'b0;
        end else begin
            clk_prev_r <= clk_prev_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------------
    // Master clear is sampled here rather than acting asynchronously,
    // because the block has one clock; it still wins over any edge.
    always_comb begin
        state_nxt = state_r;
        if (!master_clear_n_in) begin
            state_nxt = `USR_RESET_VAL;
        end else if (clk_rise) begin
            unique case (mode)
                usr_pkg::USR_LOAD: begin
                    state_nxt = par_data_in;
                end
                usr_pkg::USR_RIGHT: begin
                    state_nxt = shift_right_f(state_r, right_shift_serial_in);
                end
                usr_pkg::USR_LEFT: begin
                    state_nxt = shift_left_f(state_r, left_shift_serial_in);
                end
                usr_pkg::USR_HOLD: begin
                    state_nxt = state_r;
                end
            endcase
        end
    end

    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            state_r <= `USR_RESET_VAL;
        end else begin
            state_r <= state_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Parallel pins
    // ------------------------------------------------------------------
    // Registered from the next state so the pins show a new value at the
    // same edge that takes it; the enable lags its inputs by one edge.
    always_comb begin
        par_nxt.data = state_nxt;
        if (pins_driven_f(out_en1_n_in, out_en2_n_in, mode)) begin
            par_nxt.oe = '1;
        end else begin
            par_nxt.oe = '0;
        end
    end

    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            par_r <= '0;
        end else begin
            par_r <= par_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Serial outputs
    // ------------------------------------------------------------------
    // The end bits are shown whatever the enables do, so a chain of
    // registers keeps shifting while the shared pins are floated.
    always_comb begin
        ser_nxt.serial_q0 = state_nxt[0];
        ser_nxt.serial_q7 = state_nxt[`USR_MSB];
    end

    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            ser_r <= '0;
        end else begin
            ser_r <= ser_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Output ports
    // ------------------------------------------------------------------
    assign par_out    = par_r;
    assign serial_out = ser_r;

endmodule

`default_nettype wire

/* File: testbench/usr_shift_reg_props.sv */
`default_nettype none
module usr_shift_reg_props (
    input wire logic                     mclk_in, srst_in, shift_clock_in, master_clear_n_in,
    input wire logic [1:0]               mode_sel_in,
    input wire logic                     right_shift_serial_in, left_shift_serial_in,
    input wire logic                     out_en1_n_in, out_en2_n_in,
    input wire logic [7:0]               par_data_in,
    input wire usr_pkg::usr_par_out_t    par_out,
    input wire usr_pkg::usr_serial_out_t serial_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic sc_r;
    always_ff @(posedge mclk_in) sc_r <= srst_in ? 1'b0 : shift_clock_in;
    default clocking @(posedge mclk_in); endclocking
    default disable iff (srst_in);
    sequence take_s;
        master_clear_n_in && shift_clock_in && !sc_r;
    endsequence
    clear_zero_a: assert property (!master_clear_n_in |=> par_out.data == 8'h00)
        else $error("clear");
    load_a: assert property (take_s ##0 mode_sel_in == 2'h3 |=>
        par_out.data == $past(par_data_in)) else $error("load");
    right_a: assert property (take_s ##0 mode_sel_in == 2'h1 |=>
        par_out.data == {$past(par_out.data[6:0]), $past(right_shift_serial_in)})
        else $error("right");
    left_a: assert property (take_s ##0 mode_sel_in == 2'h2 |=>
        par_out.data == {$past(left_shift_serial_in), $past(par_out.data[7:1])})
        else $error("left");
    hold_a: assert property (master_clear_n_in && mode_sel_in == 2'h0 |=>
        $stable(par_out.data)) else $error("hold");
    idle_a: assert property (master_clear_n_in && !(shift_clock_in && !sc_r) |=>
        $stable(par_out.data)) else $error("idle");
    float_a: assert property (out_en1_n_in || out_en2_n_in || mode_sel_in == 2'h3 |=>
        par_out.oe == 8'h00) else $error("float");
    drive_a: assert property (!out_en1_n_in && !out_en2_n_in && mode_sel_in != 2'h3 |=>
        par_out.oe == 8'hFF) else $error("drive");
    serial_a: assert property (serial_out == {par_out.data[0], par_out.data[7]})
        else $error("serial");
endmodule
bind usr_shift_reg usr_shift_reg_props u_props (.*);
`default_nettype wire

/* File: testbench/usr_bus_model.sv */
`default_nettype none
module usr_bus_model (
    input wire logic       mclk_in, host_en_in,
    input wire logic [7:0] dev_data_in, dev_oe_in, host_data_in,
    output logic [7:0]     pin_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] last_r = 8'h00;
    always @(posedge mclk_in) last_r <= pin_out;
    // A pin nobody drives shows the inverse of its last level, so a float never reads as data.
    assign pin_out = (dev_oe_in & dev_data_in) |
        (~dev_oe_in & (host_en_in ? host_data_in : ~last_r));
endmodule
`default_nettype wire

/* File: testbench/usr_shift_reg_bench.sv */
`default_nettype none
`define CHK(n, e, a) begin samples_checked++; if ((a) !== (e)) begin \
    $display("ERROR %s exp %h got %h", n, e, a); err_count++; end end
module usr_shift_reg_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, rst = 1, sc = 0, clr = 1, rs = 0, ls = 0, e1 = 1, e2 = 1, hen = 0, psc = 0;
    logic [1:0] md = 2'h0;
    logic [7:0] pin, hd = 8'h00, exp_q = 8'h00, exp_oe = 8'h00;
    int err_count = 0, samples_checked = 0;
    usr_pkg::usr_par_out_t po;
    usr_pkg::usr_serial_out_t so;
    usr_shift_reg dut (.mclk_in(clk), .srst_in(rst), .shift_clock_in(sc), .master_clear_n_in(clr),
        .mode_sel_in(md), .right_shift_serial_in(rs), .left_shift_serial_in(ls), .out_en1_n_in(e1),
        .out_en2_n_in(e2), .par_data_in(pin), .par_out(po), .serial_out(so));
    usr_bus_model far (.mclk_in(clk), .host_en_in(hen), .dev_data_in(po.data), .dev_oe_in(po.oe),
        .host_data_in(hd), .pin_out(pin));
    function automatic logic [7:0] nxt(logic [7:0] s);
        case (md)
            2'h1: return {s[6:0], rs};
            2'h2: return {ls, s[7:1]};
            2'h3: return pin;
            default: return s;
        endcase
    endfunction
    task automatic complete_run;
        if (err_count == 0 && samples_checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    initial forever #20 clk = ~clk;
    initial begin
        #80000;
        err_count++;
        complete_run;
    end
    initial begin
        void'($urandom(84770));
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        for (int i = 0; i < 600; i++) begin
            @(posedge clk);
            exp_q = !clr ? 8'h00 : (sc && !psc) ? nxt(exp_q) : exp_q;
            psc = sc;
            exp_oe = (!e1 && !e2 && md != 2'h3) ? 8'hFF : 8'h00;
            {sc, rs, ls, e1, e2, hen, md, hd} <= 16'($urandom);
            clr <= ($urandom % 16) != 0;
            // Loads with both enables low check that load mode still floats the pins.
            if (i % 50 < 4) {md, e1, e2} <= 4'hC;
            @(negedge clk);
            `CHK("data", exp_q, po.data)
            `CHK("oe", exp_oe, po.oe)
            `CHK("serial", {exp_q[0], exp_q[7]}, so)
        end
        complete_run;
    end
endmodule
`default_nettype wire
